//--- rtl/lmsb_defines.vh
// Constants for the LED matrix scan and breath controller.
`ifndef LMSB_DEFINES_VH
`define LMSB_DEFINES_VH

// Register pages seen on the byte register port.
`define LMSB_PAGE_PWM        2'h1
`define LMSB_PAGE_MODE       2'h2
`define LMSB_PAGE_FUNC       2'h3

// Function page offsets.
`define LMSB_OFS_CONFIG      8'h00
`define LMSB_OFS_TIME_FIRST  8'h02
`define LMSB_OFS_TIME_LAST   8'h0D
`define LMSB_OFS_TIME_UPDATE 8'h0E
`define LMSB_OFS_PULLUP      8'h0F
`define LMSB_OFS_PULLDOWN    8'h10
`define LMSB_OFS_RESET       8'h11
`define LMSB_DOT_COUNT       8'hC0
`define LMSB_TIME_UPDATE_KEY 8'h00

// Field positions.
`define LMSB_CFG_BREATH_EN   1
`define LMSB_CODE_MSB        2
`define LMSB_RAMP_MSB        7
`define LMSB_RAMP_LSB        5
`define LMSB_HOLD_MSB        4
`define LMSB_HOLD_LSB        1
`define LMSB_END_MSB         7
`define LMSB_END_LSB         6
`define LMSB_BEGIN_MSB       5
`define LMSB_BEGIN_LSB       4
`define LMSB_LOOPHI_MSB      3

// Reset values.
`define LMSB_RST_BYTE        8'h00
`define LMSB_RST_CODE        3'h0

// Timing, in nanoseconds as printed, and the clock period.
`define LMSB_CLK_NS          8
`define LMSB_SCAN_NS         128000
`define LMSB_NOL_NS          8000
`define LMSB_BREATH_UNIT_NS  210000000
`define LMSB_STEPS_PER_RAMP  256
`define LMSB_SCAN_CYC        (`LMSB_SCAN_NS / `LMSB_CLK_NS)
`define LMSB_NOL_CYC ((`LMSB_NOL_NS + `LMSB_CLK_NS - 1) / `LMSB_CLK_NS)
`define LMSB_BREATH_STEP_CYC \
  (`LMSB_BREATH_UNIT_NS / (`LMSB_CLK_NS * `LMSB_STEPS_PER_RAMP))

`endif

//--- rtl/lmsb_led_matrix_ctrl.v
// LED matrix scan, per-dot PWM and auto breath controller.
`include "lmsb_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module lmsb_led_matrix_ctrl #(
  parameter [31:0] SCAN_CYC        = `LMSB_SCAN_CYC,
  parameter [31:0] BREATH_STEP_CYC = `LMSB_BREATH_STEP_CYC
) (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [1:0]  reg_page_in,
  input  wire [7:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  output reg  [11:0] column_switch_out,
  output reg  [15:0] row_current_source_out,
  output reg  [2:0]  column_pullup_code_out,
  output reg  [2:0]  row_pulldown_code_out
);

  localparam [31:0] NOL_CYC  = `LMSB_NOL_CYC;
  localparam [31:0] SLOT_CYC = SCAN_CYC + NOL_CYC;
  localparam [1:0]  PH_RISE  = 2'h0;
  localparam [1:0]  PH_HOLD  = 2'h1;
  localparam [1:0]  PH_FALL  = 2'h2;
  localparam [1:0]  PH_OFF   = 2'h3;
  localparam [3:0]  COL_LAST = 4'hB;

  // Length of a phase in breath steps; ramps never collapse to zero.
  function [18:0] phase_steps;
    input [3:0] code;
    input       ramp;
    begin
      if (ramp) begin
        phase_steps = 19'h00100 << code[2:0];
      end else if (code == 4'h0) begin
        phase_steps = 19'h00000;
      end else if (code > 4'hA) begin
        phase_steps = 19'h40000;
      end else begin
        phase_steps = 19'h00100 << (code - 4'h1);
      end
    end
  endfunction

  function page_hit;
    input [1:0] page;
    input [7:0] ofs;
    begin
      page_hit = (reg_page_in == page) && (reg_addr_in == ofs);
    end
  endfunction

  // Both dot pages share one decode of the 192 dot offsets.
  function dot_hit;
    input [1:0] page;
    begin
      dot_hit = (reg_page_in == page) && (reg_addr_in < `LMSB_DOT_COUNT);
    end
  endfunction

  reg  [7:0]  pwm_q    [0:191];
  reg  [1:0]  mode_q   [0:191];
  reg  [7:0]  shadow_q [0:11];
  reg  [7:0]  active_q [0:11];
  reg         breath_en_q;
  reg         breath_en_prev_q;
  reg  [2:0]  pullup_q;
  reg  [2:0]  pulldown_q;
  reg  [31:0] slot_cnt_q;
  reg  [3:0]  col_q;
  reg  [31:0] step_cnt_q;
  wire [7:0]  prof_level [0:2];
  integer     i;

  wire soft_clr = reg_rd_in &&
    page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_RESET);
  wire clr = sys_rst_in | soft_clr;
  wire time_addr = (reg_page_in == `LMSB_PAGE_FUNC) &&
    (reg_addr_in >= `LMSB_OFS_TIME_FIRST) &&
    (reg_addr_in <= `LMSB_OFS_TIME_LAST);
  wire [3:0] time_idx = reg_addr_in[3:0] - 4'h2;
  wire update = reg_wr_in && (reg_wdata_in == `LMSB_TIME_UPDATE_KEY) &&
    page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_TIME_UPDATE);
  // Profiles restart on an update or on a rising breath enable, so the host
  // must update timing before enabling to get a clean first loop.
  wire restart = update | (breath_en_q & ~breath_en_prev_q);
  wire step = (step_cnt_q == BREATH_STEP_CYC - 32'h1);
  wire in_scan = slot_cnt_q < SCAN_CYC;

  // Register writes, shadow timing storage and reset to defaults.
  always @(posedge clk_in) begin
    if (clr) begin
      for (i = 0; i < 192; i = i + 1) begin
        pwm_q[i]  <= `LMSB_RST_BYTE;
        mode_q[i] <= 2'h0;
      end
      for (i = 0; i < 12; i = i + 1) begin
        shadow_q[i] <= `LMSB_RST_BYTE;
        active_q[i] <= `LMSB_RST_BYTE;
      end
      breath_en_q      <= 1'b0;
      breath_en_prev_q <= 1'b0;
      pullup_q         <= `LMSB_RST_CODE;
      pulldown_q       <= `LMSB_RST_CODE;
    end else begin
      breath_en_prev_q <= breath_en_q;
      if (reg_wr_in) begin
        if (dot_hit(`LMSB_PAGE_PWM)) begin
          pwm_q[reg_addr_in] <= reg_wdata_in;
        end
        if (dot_hit(`LMSB_PAGE_MODE)) begin
          mode_q[reg_addr_in] <= reg_wdata_in[1:0];
        end
        if (time_addr) begin
          shadow_q[time_idx] <= reg_wdata_in;
        end
        if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG)) begin
          breath_en_q <= reg_wdata_in[`LMSB_CFG_BREATH_EN];
        end
        if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLUP)) begin
          pullup_q <= reg_wdata_in[`LMSB_CODE_MSB:0];
        end
        if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLDOWN)) begin
          pulldown_q <= reg_wdata_in[`LMSB_CODE_MSB:0];
        end
      end
      if (update) begin
        for (i = 0; i < 12; i = i + 1) begin
          active_q[i] <= shadow_q[i];
        end
      end
    end
  end

  // Read data; the reset register itself reads as zero.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 8'h00;
      if (dot_hit(`LMSB_PAGE_PWM)) begin
        reg_rdata_out <= pwm_q[reg_addr_in];
      end else if (dot_hit(`LMSB_PAGE_MODE)) begin
        reg_rdata_out <= {6'h00, mode_q[reg_addr_in]};
      end else if (time_addr) begin
        reg_rdata_out <= shadow_q[time_idx];
      end else if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_CONFIG)) begin
        reg_rdata_out <= {6'h00, breath_en_q, 1'b0};
      end else if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLUP)) begin
        reg_rdata_out <= {5'h00, pullup_q};
      end else if (page_hit(`LMSB_PAGE_FUNC, `LMSB_OFS_PULLDOWN)) begin
        reg_rdata_out <= {5'h00, pulldown_q};
      end
    end
  end

  // Shared breath step prescaler, one unit of ramp resolution.
  // All profiles share it, so any restart realigns the steps of all three.
  always @(posedge clk_in) begin
    if (clr || restart || step) begin
      step_cnt_q <= 32'h0;
    end else begin
      step_cnt_q <= step_cnt_q + 32'h1;
    end
  end

  // One sequencer per breath profile.
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_prof
      reg  [1:0]  phase_q;
      reg  [18:0] pcnt_q;
      reg  [11:0] loops_q;
      reg         extra_q;
      reg         stopped_q;
      reg         stop_on_q;
      reg  [7:0]  level;
      reg  [18:0] len;
      wire [7:0]  cfg1 = active_q[4 * p];
      wire [7:0]  cfg2 = active_q[4 * p + 1];
      wire [7:0]  cfg3 = active_q[4 * p + 2];
      wire [7:0]  cfg4 = active_q[4 * p + 3];
      wire [2:0]  rise_time = cfg1[`LMSB_RAMP_MSB:`LMSB_RAMP_LSB];
      wire [3:0]  hold_on_time = cfg1[`LMSB_HOLD_MSB:`LMSB_HOLD_LSB];
      wire [2:0]  fall_time = cfg2[`LMSB_RAMP_MSB:`LMSB_RAMP_LSB];
      wire [3:0]  off_time = cfg2[`LMSB_HOLD_MSB:`LMSB_HOLD_LSB];
      wire        end_on = cfg3[`LMSB_END_LSB];
      wire [1:0]  begin_ph = cfg3[`LMSB_BEGIN_MSB:`LMSB_BEGIN_LSB];
      wire [11:0] loop_limit =
        {cfg3[`LMSB_LOOPHI_MSB:0], cfg4};
      wire        last = (len == 19'h0) || (pcnt_q >= len - 19'h1);
      wire        loop_done = (loop_limit != 12'h0) &&
        (loops_q + 12'h1 == loop_limit);
      // The shift folds every ramp length back onto 256 levels.
      wire [17:0] rise_lvl = pcnt_q[17:0] >> rise_time;
      wire [17:0] fall_lvl = pcnt_q[17:0] >> fall_time;

      always @* begin
        case (phase_q)
          PH_RISE: len = phase_steps({1'b0, rise_time}, 1'b1);
          PH_HOLD: len = phase_steps(hold_on_time, 1'b0);
          PH_FALL: len = phase_steps({1'b0, fall_time}, 1'b1);
          PH_OFF:  len = phase_steps(off_time, 1'b0);
          default: len = 19'h0;
        endcase
        if (stopped_q) begin
          level = stop_on_q ? 8'hFF : 8'h00;
        end else begin
          case (phase_q)
            PH_RISE: level = rise_lvl[7:0];
            PH_HOLD: level = 8'hFF;
            PH_FALL: level = 8'hFF - fall_lvl[7:0];
            default: level = 8'h00;
          endcase
        end
      end

      always @(posedge clk_in) begin
        if (clr || restart) begin
          phase_q   <= clr ? PH_RISE : begin_ph;
          pcnt_q    <= 19'h0;
          loops_q   <= 12'h0;
          extra_q   <= 1'b0;
          stopped_q <= 1'b0;
          stop_on_q <= 1'b0;
        end else if (step && !stopped_q) begin
          if (!last) begin
            pcnt_q <= pcnt_q + 19'h1;
          end else begin
            pcnt_q  <= 19'h0;
            phase_q <= phase_q + 2'h1;
            if (phase_q == PH_FALL && !extra_q) begin
              loops_q <= loops_q + 12'h1;
              if (loop_done && !end_on) begin
                stopped_q <= 1'b1;
              end else if (loop_done) begin
                extra_q <= 1'b1;
              end
            end
            if (phase_q == PH_RISE && extra_q) begin
              stopped_q <= 1'b1;
              stop_on_q <= 1'b1;
            end
          end
        end
      end

      assign prof_level[p] = level;
    end
  endgenerate

  // Column scan with non-overlap blanking, wrapping after column twelve.
  always @(posedge clk_in) begin
    if (clr) begin
      slot_cnt_q <= 32'h0;
      col_q      <= 4'h0;
    end else if (slot_cnt_q == SLOT_CYC - 32'h1) begin
      slot_cnt_q <= 32'h0;
      if (col_q == COL_LAST) begin
        col_q <= 4'h0;
      end else begin
        col_q <= col_q + 4'h1;
      end
    end else begin
      slot_cnt_q <= slot_cnt_q + 32'h1;
    end
  end

  // Row drive for the dots of the active column, compared exactly so the
  // on time is value/256 of SCAN_CYC even though SCAN_CYC is not 256-aligned.
  wire [15:0] row_d;
  genvar r;
  generate
    for (r = 0; r < 16; r = r + 1) begin : g_row
      localparam [3:0] RI = r;
      wire [7:0]  dot = {col_q, RI};
      wire [1:0]  mode = mode_q[dot];
      wire [7:0]  bright = (breath_en_q && mode != 2'h0) ?
        prof_level[mode - 2'h1] : pwm_q[dot];
      wire [39:0] lhs = {8'h00, slot_cnt_q} << 8;
      wire [39:0] rhs = {32'h0, bright} * {8'h00, SCAN_CYC};
      assign row_d[r] = in_scan && (lhs < rhs);
    end
  endgenerate

  always @(posedge clk_in) begin
    if (clr) begin
      column_switch_out      <= 12'h000;
      row_current_source_out <= 16'h0000;
      column_pullup_code_out <= 3'h0;
      row_pulldown_code_out  <= 3'h0;
    end else if (in_scan) begin
      column_switch_out      <= 12'h001 << col_q;
      row_current_source_out <= row_d;
      column_pullup_code_out <= 3'h0;
      row_pulldown_code_out  <= 3'h0;
    end else begin
      // Pulls are shown only in the gap, so they never fight a lit column.
      column_switch_out      <= 12'h000;
      row_current_source_out <= row_d;
      column_pullup_code_out <= pullup_q;
      row_pulldown_code_out  <= pulldown_q;
    end
  end

endmodule // lmsb_led_matrix_ctrl

`default_nettype wire

//--- tb/lmsb_ctrl_sva.sv
// Checker of column scan, blanking, pull codes and reset reads.
`timescale 1ns/1ns
`default_nettype none
module lmsb_ctrl_sva #(
  parameter [31:0] SCAN_CYC = 32'h200
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [1:0]  reg_page_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [11:0] column_switch_out,
  input wire logic [15:0] row_current_source_out,
  input wire logic [2:0]  column_pullup_code_out,
  input wire logic [2:0]  row_pulldown_code_out
);
  wire rd_rst = reg_rd_in && reg_page_in == 2'h3 && reg_addr_in == 8'h11;
  wire col_on = column_switch_out != 12'h000;
  logic        rd_d_q;
  logic        arm_q;
  logic [11:0] last_q;
  logic [31:0] on_q;
  logic [31:0] off_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // A reset read may restart the scan, so slot counts start over after it.
  always @(posedge clk_in) begin
    rd_d_q <= rd_rst;
    if (sys_rst_in || rd_rst || rd_d_q) begin
      arm_q <= 1'b0;
      last_q <= 12'h000;
      on_q <= 32'h0;
      off_q <= 32'h0;
    end else if (col_on) begin
      arm_q <= arm_q || off_q != 32'h0;
      last_q <= column_switch_out;
      on_q <= on_q + 32'h1;
      off_q <= 32'h0;
    end else begin
      on_q <= 32'h0;
      off_q <= off_q + 32'h1;
    end
  end
  a_col_single: assert property ($onehot0(column_switch_out))
    else $error("more than one column on");
  a_pullup_blank: assert property (column_pullup_code_out != 3'h0 |-> !col_on)
    else $error("pull-up code outside blanking");
  a_pulldn_blank: assert property (row_pulldown_code_out != 3'h0 |-> !col_on)
    else $error("pull-down code outside blanking");
  a_rows_col: assert property (row_current_source_out != 16'h0 |-> col_on)
    else $error("row source on with no column");
  a_on_len: assert property (arm_q && !col_on && on_q != 0 |-> on_q == SCAN_CYC)
    else $error("column on time wrong");
  a_blank_len: assert property (arm_q && col_on && off_q != 0 |-> off_q == 1000)
    else $error("blanking time wrong");
  a_col_order: assert property (arm_q && col_on && off_q != 0 |->
    column_switch_out == {last_q[10:0], last_q[11]})
    else $error("column order wrong");
  a_rst_read: assert property (rd_rst |=> reg_rdata_out == 8'h00 ##1
    (column_pullup_code_out == 3'h0 && row_pulldown_code_out == 3'h0)[*8])
    else $error("reset read left state");
  a_start_blank: assert property ($fell(sys_rst_in) |->
    row_current_source_out == 16'h0 && column_pullup_code_out == 3'h0)
    else $error("display not blank after reset");
  a_upd_read: assert property (reg_rd_in && reg_page_in == 2'h3 &&
    reg_addr_in == 8'h0E |=> reg_rdata_out == 8'h00)
    else $error("update register read not zero");
  c_wrap: cover property (arm_q && off_q != 0 && column_switch_out == 12'h001);
  c_rst_read: cover property (rd_rst);
  c_pullup: cover property (column_pullup_code_out == 3'h5);
endmodule // lmsb_ctrl_sva
`default_nettype wire

//--- tb/lmsb_matrix_model.sv
// Behavioural LED matrix that totals the lit cycles of every dot.
`timescale 1ns/1ns
`default_nettype none
module lmsb_matrix_model (
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic        hold_in,
  input  wire logic [11:0] column_switch_in,
  input  wire logic [15:0] row_current_source_in,
  input  wire logic [7:0]  sel_in,
  output logic      [15:0] lit_out
);
  logic [15:0] lit_q [0:191];
  integer      c;
  integer      r;
  // A dot glows only while its column switch and its row source both conduct.
  // Totals freeze while hold is high, so they can be read after a frame.
  always @(posedge clk_in) begin
    for (c = 0; c < 12; c = c + 1) begin
      for (r = 0; r < 16; r = r + 1) begin
        if (clr_in)
          lit_q[c*16+r] <= 16'h0000;
        else if (!hold_in && column_switch_in[c] &&
                 row_current_source_in[r])
          lit_q[c*16+r] <= lit_q[c*16+r] + 16'h0001;
      end
    end
  end
  assign lit_out = lit_q[sel_in];
endmodule // lmsb_matrix_model
`default_nettype wire

//--- tb/lmsb_led_matrix_ctrl_test.sv
// Self-checking bench of the LED matrix scan and breath controller.
`timescale 1ns/1ns
`default_nettype none
module lmsb_led_matrix_ctrl_test;
  localparam [31:0] SCAN = 32'h200;
  localparam integer FRAME = 12 * (512 + 1000);
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [1:0]  pg = 2'h0;
  logic [7:0]  ad = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        clr = 1'b0;
  logic        hold = 1'b1;
  logic [7:0]  sel = 8'h00;
  wire  [7:0]  rdata;
  wire  [11:0] col;
  wire  [15:0] row;
  wire  [2:0]  pu;
  wire  [2:0]  pd;
  wire  [15:0] lit;
  logic [31:0] rows [0:6];
  integer      err_total = 0;
  integer      samples_checked = 0;
  integer      i;
  integer      k;
  lmsb_led_matrix_ctrl #(.SCAN_CYC(SCAN), .BREATH_STEP_CYC(32'h2))
    lmsb_led_matrix_ctrl_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_page_in(pg), .reg_addr_in(ad), .reg_wr_in(wr), .reg_wdata_in(wd),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .column_switch_out(col),
    .row_current_source_out(row), .column_pullup_code_out(pu),
    .row_pulldown_code_out(pd));
  lmsb_matrix_model lmsb_matrix_model_i (.clk_in(clk_in), .clr_in(clr),
    .hold_in(hold),
    .column_switch_in(col), .row_current_source_in(row), .sel_in(sel),
    .lit_out(lit));
  always #4 clk_in = ~clk_in;
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wreg(input [1:0] p, input [7:0] a, input [7:0] d);
    @(negedge clk_in);
    pg = p; ad = a; wd = d; wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  task rreg(input [1:0] p, input [7:0] a, input [7:0] e);
    @(negedge clk_in);
    pg = p; ad = a; rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  // Any start inside a blanking gap covers each dot's slot exactly once.
  task wblank;
    k = 0;
    while (col !== 12'h000) begin
      @(negedge clk_in);
      k = k + 1;
      if (k > 2000) begin
        err_total = err_total + 1;
        complete_run;
      end
    end
  endtask
  task frame;
    wblank;
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    hold = 1'b0;
    repeat (FRAME) @(negedge clk_in);
    hold = 1'b1;
  endtask
  task dot(input [7:0] d, input [15:0] e);
    sel = d;
    #1;
    chk("lit", lit, e);
  endtask
  initial begin
    rows[0] = 32'h05040008;
    rows[1] = 32'h06040008;
    rows[2] = 32'h07040008;
    rows[3] = 32'h00000000;
    rows[4] = 32'h11FF01FE;
    rows[5] = 32'h64010002;
    rows[6] = 32'hBF800100;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rreg(2'h3, 8'h0F, 8'h00);
    rreg(2'h3, 8'h10, 8'h00);
    for (i = 0; i < 7; i = i + 1) wreg(2'h1, rows[i][31:24], rows[i][23:16]);
    for (i = 1; i < 4; i = i + 1) wreg(2'h2, 8'h04 + i, i);
    wreg(2'h1, 8'h20, 8'h0A);
    rreg(2'h1, 8'h05, 8'h04);
    frame;
    for (i = 0; i < 7; i = i + 1) dot(rows[i][31:24], rows[i][15:0]);
    dot(8'h20, 16'h0014);
    for (i = 0; i < 3; i = i + 1) begin
      wreg(2'h3, 8'h02 + 4 * i, 8'h10);
      wreg(2'h3, 8'h04 + 4 * i, 8'h10);
    end
    wreg(2'h3, 8'h0E, 8'h01);
    rreg(2'h3, 8'h02, 8'h10);
    rreg(2'h3, 8'h0E, 8'h00);
    wreg(2'h3, 8'h00, 8'h02);
    frame;
    sel = 8'h05;
    #1;
    chk("stale", {15'h0, lit == 16'h01FE}, 16'h0000);
    wreg(2'h3, 8'h0E, 8'h00);
    frame;
    for (i = 5; i < 8; i = i + 1) dot(i, 16'h01FE);
    wreg(2'h3, 8'h00, 8'h00);
    frame;
    dot(8'h05, 16'h0008);
    wreg(2'h3, 8'h0F, 8'h05);
    wreg(2'h3, 8'h10, 8'h07);
    rreg(2'h3, 8'h0F, 8'h05);
    rreg(2'h3, 8'h10, 8'h07);
    wblank;
    chk("pullup", {13'h0, pu}, 16'h0005);
    chk("pulldown", {13'h0, pd}, 16'h0007);
    rreg(2'h3, 8'h20, 8'h00);
    rreg(2'h3, 8'h11, 8'h00);
    rreg(2'h3, 8'h0F, 8'h00);
    rreg(2'h1, 8'h05, 8'h00);
    wblank;
    @(negedge clk_in);
    chk("pulldown", {13'h0, pd}, 16'h0000);
    wreg(2'h3, 8'h0F, 8'h03);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk("pullup", {13'h0, pu}, 16'h0000);
    rreg(2'h3, 8'h0F, 8'h00);
    complete_run;
  end
endmodule // lmsb_led_matrix_ctrl_test
bind lmsb_led_matrix_ctrl lmsb_ctrl_sva #(.SCAN_CYC(SCAN_CYC)) lmsb_ctrl_sva_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_page_in(reg_page_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .column_switch_out(column_switch_out),
  .row_current_source_out(row_current_source_out),
  .column_pullup_code_out(column_pullup_code_out),
  .row_pulldown_code_out(row_pulldown_code_out));
`default_nettype wire
